// *** hw/msi_regs.svh ***
// Purpose: Constants for the serial init receiver of a packet DRAM device
// Assumes: Serial link clock is sampled by the 200 MHz system clock
// Notes: Field positions of the setup register are local choices
//
// Contract
// - Serial reset clears seven registers, presets setup
// - Broadcast powerdown wake moves device to relax
// - Fast clock locks domain, stores autoskip only while soft and serial reset are inactive
// - Release soft reset leaves core data undefined
// - Opcode 0010 asserts reset, 16 cycle wait
// - Opcode 1011 releases reset, 4 cycle wait
// - Opcode 0100 fast clock, 4 cycle wait
// - Request framed by 11110000 on both edges
`ifndef MSI_REGS_SVH
`define MSI_REGS_SVH

// ---------------------------------------------------------------------
// Framing and packet
// ---------------------------------------------------------------------
`define MSI_FRAME_PATTERN 8'hf0
`define MSI_PKT_LAST 4'hf
`define MSI_SOP_MSB 9
`define MSI_SOP_LSB 6
`define MSI_SBC_BIT 5
`define MSI_SDEV_HI_BIT 10
`define MSI_SDEV_LO_MSB 4

// ---------------------------------------------------------------------
// Opcodes and guard intervals in serial clock cycles
// ---------------------------------------------------------------------
`define MSI_OP_ASSERT_RST 4'h2
`define MSI_OP_RELEASE_RST 4'hb
`define MSI_OP_FAST_CLK 4'h4
`define MSI_WAIT_ASSERT_RST 5'h10
`define MSI_WAIT_RELEASE_RST 5'h04
`define MSI_WAIT_FAST_CLK 5'h04

// ---------------------------------------------------------------------
// Setup register layout and reset values
// ---------------------------------------------------------------------
`define MSI_SETUP_ID_MSB 5
`define MSI_SETUP_ID_LSB 0
`define MSI_SETUP_SKIP_BIT 6
`define MSI_SETUP_LOWPWR_SR_BIT 7
`define MSI_SETUP_LIGHT_SR_BIT 8
`define MSI_SETUP_PDOWN_SR_BIT 9
`define MSI_SETUP_RESET 16'h007f
`define MSI_ZERO16 16'h0000
`define MSI_ZERO7 7'h00

`endif

// *** hw/msi_pkg.sv ***
// Purpose: Types for the serial init receiver
// Assumes: Constants come from msi_regs.svh
// Notes: None
package msi_pkg;

  typedef enum logic [1:0] {
    MSI_PWR_POWERDOWN,
    MSI_PWR_RELAX
  } msi_power_type;

  typedef enum logic [2:0] {
    MSI_SEL_SETUP,
    MSI_SEL_SCRATCH_A,
    MSI_SEL_DRIVE_A,
    MSI_SEL_DRIVE_B,
    MSI_SEL_SCRATCH_C,
    MSI_SEL_SCRATCH_D
  } msi_sel_type;

  typedef struct packed {
    logic [15:0] scratch_test_reg_a;
    logic [6:0] drive_current_a;
    logic [6:0] drive_current_b;
    logic skip_field;
    logic autoskip_flag;
    logic [15:0] scratch_test_reg_c;
    logic [15:0] scratch_test_reg_d;
  } msi_cleared_type;

  typedef struct packed {
    logic wr;
    msi_sel_type sel;
    logic [15:0] data;
  } msi_wr_type;

endpackage

// *** hw/msi_top.sv ***
// Purpose: Device side of the serial config link power-up sequence
// Assumes: Link clock, command, data and strap pins are asynchronous
// Notes: Register writes arrive on the same clock from the packet decoder
`timescale 1ns/1ps
`include "msi_regs.svh"

module msi_top
  import msi_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic SCK_I,
  input wire logic CMD_I,
  input wire logic SIO_IN_I,
  input wire logic SIO_RESET_I,
  input wire logic POWERDOWN_WAKE_I,
  input wire logic READ_DOMAIN_I,
  input wire msi_wr_type REG_WR_I,
  output logic [15:0] SETUP_REG_O,
  output msi_cleared_type CLEARED_REGS_O,
  output msi_power_type POWER_STATE_O,
  output logic SOFT_RESET_O,
  output logic FAST_CLOCK_O,
  output logic READ_DOMAIN_O,
  output logic CORE_DATA_UNDEFINED_O,
  output logic SEQ_ERROR_O,
  output logic [3:0] LAST_OPCODE_O
);

  // -------------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // -------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_meta_r;
  logic [NPIN-1:0] pin_sync_r;
  logic [NPIN-1:0] pin_raw;

  assign pin_raw = {READ_DOMAIN_I, POWERDOWN_WAKE_I, SIO_RESET_I, SIO_IN_I, CMD_I, SCK_I};

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta_r[g] <= 1'h0;
          pin_sync_r[g] <= 1'h0;
        end else begin
          pin_meta_r[g] <= pin_raw[g];
          pin_sync_r[g] <= pin_meta_r[g];
        end
      end
    end
  endgenerate

  logic sck_s, cmd_s, sio_s, sio_rst_s, wake_s, domain_s;
  assign {domain_s, wake_s, sio_rst_s, sio_s, cmd_s, sck_s} = pin_sync_r;

  // -------------------------------------------------------------------
  // Link clock edges
  // -------------------------------------------------------------------
  logic sck_d_r;
  logic sck_rise;
  logic sck_fall;

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_r <= 1'h0;
    end else begin
      sck_d_r <= sck_s;
    end
  end
  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;

  // -------------------------------------------------------------------
  // Framing and packet capture
  // -------------------------------------------------------------------
  logic [7:0] frame_r;
  logic [7:0] frame_nxt;
  logic capturing_r;
  logic [3:0] bit_cnt_r;
  logic [15:0] pkt_r;
  logic [15:0] pkt_nxt;
  logic frame_hit;
  logic pkt_done;

  assign frame_nxt = {frame_r[6:0], cmd_s};
  assign frame_hit = (sck_rise | sck_fall) & ~capturing_r
                     & (frame_nxt == `MSI_FRAME_PATTERN);
  assign pkt_nxt = {pkt_r[14:0], sio_s};
  assign pkt_done = capturing_r & sck_fall & (bit_cnt_r == `MSI_PKT_LAST);

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      frame_r <= 8'h00;
      capturing_r <= 1'h0;
      bit_cnt_r <= 4'h0;
      pkt_r <= 16'h0000;
    end else begin
      if (sck_rise | sck_fall) begin
        frame_r <= frame_hit ? 8'h00 : frame_nxt;
      end
      if (frame_hit) begin
        capturing_r <= 1'h1;
        bit_cnt_r <= 4'h0;
      end else if (capturing_r & sck_fall) begin
        pkt_r <= pkt_nxt;
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (pkt_done) begin
          capturing_r <= 1'h0;
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // Request decode
  // -------------------------------------------------------------------
  logic [3:0] sop;
  logic [5:0] sdev;
  logic selected;
  logic do_assert_rst;
  logic do_release_rst;
  logic do_fast_clk;

  assign sop = pkt_nxt[`MSI_SOP_MSB:`MSI_SOP_LSB];
  assign sdev = {pkt_nxt[`MSI_SDEV_HI_BIT], pkt_nxt[`MSI_SDEV_LO_MSB:0]};
  assign selected = pkt_nxt[`MSI_SBC_BIT]
                    | (sdev == SETUP_REG_O[`MSI_SETUP_ID_MSB:`MSI_SETUP_ID_LSB]);
  assign do_assert_rst = pkt_done & selected & (sop == `MSI_OP_ASSERT_RST);
  assign do_release_rst = pkt_done & selected & (sop == `MSI_OP_RELEASE_RST);
  assign do_fast_clk = pkt_done & selected & (sop == `MSI_OP_FAST_CLK);

  // -------------------------------------------------------------------
  // Guard interval after each selected assert reset, release reset or fast clock command
  // -------------------------------------------------------------------
  logic [4:0] guard_r;
  logic [4:0] guard_nxt;
  logic guard_busy;
  logic early_req;
  logic bad_pair;
  logic repeat_cmd;

  assign guard_busy = (guard_r != 5'h00);
  assign early_req = frame_hit & guard_busy;
  assign bad_pair = do_release_rst & ~SOFT_RESET_O;
  assign repeat_cmd = (do_fast_clk & FAST_CLOCK_O) | (do_assert_rst & SOFT_RESET_O);
  assign guard_nxt = do_assert_rst ? `MSI_WAIT_ASSERT_RST :
                     do_release_rst ? `MSI_WAIT_RELEASE_RST :
                     do_fast_clk ? `MSI_WAIT_FAST_CLK :
                     (sck_fall & guard_busy) ? guard_r - 5'h01 : guard_r;

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      guard_r <= 5'h00;
      SEQ_ERROR_O <= 1'h0;
      LAST_OPCODE_O <= 4'h0;
    end else begin
      guard_r <= guard_nxt;
      if (early_req | bad_pair | repeat_cmd) begin
        SEQ_ERROR_O <= 1'h1;
      end else if (sio_rst_s) begin
        SEQ_ERROR_O <= 1'h0;
      end
      if (pkt_done) begin
        LAST_OPCODE_O <= sop;
      end
    end
  end

  // -------------------------------------------------------------------
  // Registers cleared by serial reset and soft reset
  // -------------------------------------------------------------------
  logic regs_to_reset;
  logic wr_setup;
  logic wr_sa;
  logic wr_da;
  logic wr_db;
  logic wr_sc;
  logic wr_sd;

  assign regs_to_reset = sio_rst_s | do_assert_rst | SOFT_RESET_O;
  assign wr_setup = REG_WR_I.wr & (REG_WR_I.sel == MSI_SEL_SETUP);
  assign wr_sa = REG_WR_I.wr & (REG_WR_I.sel == MSI_SEL_SCRATCH_A);
  assign wr_da = REG_WR_I.wr & (REG_WR_I.sel == MSI_SEL_DRIVE_A);
  assign wr_db = REG_WR_I.wr & (REG_WR_I.sel == MSI_SEL_DRIVE_B);
  assign wr_sc = REG_WR_I.wr & (REG_WR_I.sel == MSI_SEL_SCRATCH_C);
  assign wr_sd = REG_WR_I.wr & (REG_WR_I.sel == MSI_SEL_SCRATCH_D);

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      SETUP_REG_O <= `MSI_SETUP_RESET;
      CLEARED_REGS_O <= '0;
    end else if (regs_to_reset) begin
      SETUP_REG_O <= `MSI_SETUP_RESET;
      CLEARED_REGS_O <= '0;
    end else begin
      if (wr_setup) begin
        SETUP_REG_O <= REG_WR_I.data;
      end
      if (wr_sa) begin
        CLEARED_REGS_O.scratch_test_reg_a <= REG_WR_I.data;
      end
      if (wr_da) begin
        CLEARED_REGS_O.drive_current_a <= REG_WR_I.data[6:0];
      end
      if (wr_db) begin
        CLEARED_REGS_O.drive_current_b <= REG_WR_I.data[6:0];
      end
      if (wr_sc) begin
        CLEARED_REGS_O.scratch_test_reg_c <= REG_WR_I.data;
      end
      if (wr_sd) begin
        CLEARED_REGS_O.scratch_test_reg_d <= REG_WR_I.data;
      end
      if (do_fast_clk) begin
        CLEARED_REGS_O.autoskip_flag <= domain_s;
        CLEARED_REGS_O.skip_field <= SETUP_REG_O[`MSI_SETUP_SKIP_BIT];
      end
    end
  end

  // -------------------------------------------------------------------
  // Soft reset, fast clock and power state
  // -------------------------------------------------------------------
  msi_power_type pwr_nxt;

  always_comb begin
    pwr_nxt = POWER_STATE_O;
    case (POWER_STATE_O)
      MSI_PWR_POWERDOWN: begin
        if (wake_s) begin
          pwr_nxt = MSI_PWR_RELAX;
        end
      end
      MSI_PWR_RELAX: begin
        if (sio_rst_s) begin
          pwr_nxt = MSI_PWR_POWERDOWN;
        end
      end
      default: begin
        pwr_nxt = MSI_PWR_POWERDOWN;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      POWER_STATE_O <= MSI_PWR_POWERDOWN;
      SOFT_RESET_O <= 1'h0;
      FAST_CLOCK_O <= 1'h0;
      READ_DOMAIN_O <= 1'h0;
      CORE_DATA_UNDEFINED_O <= 1'h0;
    end else begin
      POWER_STATE_O <= pwr_nxt;
      if (do_assert_rst) begin
        SOFT_RESET_O <= 1'h1;
      end else if (do_release_rst | sio_rst_s) begin
        SOFT_RESET_O <= 1'h0;
      end
      if (do_release_rst & SOFT_RESET_O) begin
        CORE_DATA_UNDEFINED_O <= 1'h1;
      end
      if (do_fast_clk) begin
        FAST_CLOCK_O <= 1'h1;
        READ_DOMAIN_O <= domain_s;
      end else if (sio_rst_s) begin
        FAST_CLOCK_O <= 1'h0;
      end
    end
  end

endmodule

// *** test/msi_properties.sv ***
// Purpose: Port checks for the serial init receiver
// Assumes: One clock domain, reset from RESET_N_I
// Notes: Skip field masked, its preset value is unsettled
`timescale 1ns/1ps
`include "msi_regs.svh"
module msi_checker
  import msi_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic SIO_RESET_I,
  input wire logic POWERDOWN_WAKE_I,
  input wire logic [15:0] SETUP_REG_O,
  input wire msi_cleared_type CLEARED_REGS_O,
  input wire msi_power_type POWER_STATE_O,
  input wire logic SOFT_RESET_O,
  input wire logic FAST_CLOCK_O,
  input wire logic READ_DOMAIN_O,
  input wire logic CORE_DATA_UNDEFINED_O,
  input wire logic SEQ_ERROR_O,
  input wire logic [3:0] LAST_OPCODE_O
);
  wire logic [63:0] clr = CLEARED_REGS_O & 64'hffff_fffd_ffff_ffff;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESET_N_I);
  sequence sio_held_s;
    SIO_RESET_I [*6];
  endsequence
  sequence wake_held_s;
    (POWERDOWN_WAKE_I && !SIO_RESET_I) [*6];
  endsequence
  setup_preset_a: assert property (sio_held_s |-> SETUP_REG_O == `MSI_SETUP_RESET
    && clr == 64'h0 && POWER_STATE_O == MSI_PWR_POWERDOWN) else $error("no serial preset");
  wake_relax_a: assert property (wake_held_s |-> POWER_STATE_O == MSI_PWR_RELAX)
    else $error("wake not taken");
  soft_hold_a: assert property (SOFT_RESET_O && $past(SOFT_RESET_O)
    |-> SETUP_REG_O == `MSI_SETUP_RESET && clr == 64'h0) else $error("soft reset not held");
  soft_opcode_a: assert property ($rose(SOFT_RESET_O)
    |-> ##[0:1] LAST_OPCODE_O == `MSI_OP_ASSERT_RST) else $error("soft reset without opcode");
  undef_set_a: assert property ($fell(SOFT_RESET_O) && LAST_OPCODE_O == `MSI_OP_RELEASE_RST
    |-> CORE_DATA_UNDEFINED_O) else $error("core not marked undefined");
  undef_keep_a: assert property (CORE_DATA_UNDEFINED_O |=> CORE_DATA_UNDEFINED_O)
    else $error("undefined flag dropped");
  fast_lock_a: assert property ($rose(FAST_CLOCK_O) |-> ##[0:1] (LAST_OPCODE_O ==
    `MSI_OP_FAST_CLK && CLEARED_REGS_O.autoskip_flag == READ_DOMAIN_O)) else $error("bad lock");
  seq_keep_a: assert property (SEQ_ERROR_O && !SIO_RESET_I && !$past(SIO_RESET_I)
    && !$past(SIO_RESET_I, 2) |=> SEQ_ERROR_O) else $error("error flag dropped");
endmodule

// *** test/msi_ctrl_model.sv ***
// Purpose: Controller side of the serial config link
// Assumes: Starts on a system clock edge, SCK idle low
// Notes: SERIAL_CONFIG_LINK toggles each idle cycle and after each packet, and holds during the frame
`timescale 1ns/1ps
module msi_ctrl_model (
  input wire logic clk_i,
  output logic sck_o,
  output logic cmd_o,
  output logic sio_o
);
  localparam logic [7:0] frame = 8'hf0;
  initial begin
    sck_o = 1'b0;
    cmd_o = 1'b0;
    sio_o = 1'b0;
  end
  // Guard cycles: SCK runs, CMD low
  task idle(input int n);
    repeat (n) begin
      #40 sck_o = 1'b1;
      #80 sck_o = 1'b0;
      #40 sio_o = ~sio_o;
    end
  endtask
  task send(input logic [3:0] op, input logic bc, input logic [5:0] id);
    logic [15:0] pkt;
    pkt = {5'h00, id[5], op, bc, id[4:0]};
    @(posedge clk_i);
    #1;
    for (int i = 7; i >= 0; i--) begin
      cmd_o = frame[i];
      #40 sck_o = ~sck_o;
      #40;
    end
    for (int n = 0; n < 16; n++) begin
      sio_o = pkt[15 - n];
      #40 sck_o = 1'b1;
      #80 sck_o = 1'b0;
      #40;
    end
    sio_o = ~sio_o;
  endtask
endmodule

// *** test/tb_top.sv ***
// Purpose: Directed bench for the serial init receiver
// Assumes: Partner model drives the serial link pins
// Notes: Fixed waits follow the guard counts, except the 8 cycle wait in t_err that forces an early request
`timescale 1ns/1ps
`include "msi_regs.svh"
module tb_top
  import msi_pkg::*;
;
  logic CLK_SYS_I, RESET_N_I, SIO_RESET_I, POWERDOWN_WAKE_I, READ_DOMAIN_I;
  logic SOFT_RESET_O, FAST_CLOCK_O, READ_DOMAIN_O, CORE_DATA_UNDEFINED_O, SEQ_ERROR_O;
  wire logic SCK_I, CMD_I, SIO_IN_I;
  msi_wr_type REG_WR_I;
  logic [15:0] SETUP_REG_O;
  msi_cleared_type CLEARED_REGS_O;
  msi_power_type POWER_STATE_O;
  logic [3:0] LAST_OPCODE_O;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  wire logic [4:0] flg = {SOFT_RESET_O, FAST_CLOCK_O, READ_DOMAIN_O, CORE_DATA_UNDEFINED_O,
    SEQ_ERROR_O};
  wire logic [63:0] clr = CLEARED_REGS_O & 64'hffff_fffd_ffff_ffff;
  msi_top DUT (
    .CLK_SYS_I(CLK_SYS_I),
    .RESET_N_I(RESET_N_I),
    .SCK_I(SCK_I),
    .CMD_I(CMD_I),
    .SIO_IN_I(SIO_IN_I),
    .SIO_RESET_I(SIO_RESET_I),
    .POWERDOWN_WAKE_I(POWERDOWN_WAKE_I),
    .READ_DOMAIN_I(READ_DOMAIN_I),
    .REG_WR_I(REG_WR_I),
    .SETUP_REG_O(SETUP_REG_O),
    .CLEARED_REGS_O(CLEARED_REGS_O),
    .POWER_STATE_O(POWER_STATE_O),
    .SOFT_RESET_O(SOFT_RESET_O),
    .FAST_CLOCK_O(FAST_CLOCK_O),
    .READ_DOMAIN_O(READ_DOMAIN_O),
    .CORE_DATA_UNDEFINED_O(CORE_DATA_UNDEFINED_O),
    .SEQ_ERROR_O(SEQ_ERROR_O),
    .LAST_OPCODE_O(LAST_OPCODE_O)
  );
  msi_ctrl_model ctrl (.clk_i(CLK_SYS_I), .sck_o(SCK_I), .cmd_o(CMD_I), .sio_o(SIO_IN_I));
  initial begin
    CLK_SYS_I = 1'b0;
    forever #2.5 CLK_SYS_I = ~CLK_SYS_I;
  end
  always @(posedge CLK_SYS_I) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      results();
    end
  end
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge CLK_SYS_I);
    #1;
  endtask
  task wr(input msi_sel_type sel, input logic [15:0] d);
    REG_WR_I = '{1'b1, sel, d};
    step(1);
    REG_WR_I.wr = 1'b0;
    step(2);
  endtask
  task sio_reset;
    SIO_RESET_I = 1'b1;
    step(8);
    SIO_RESET_I = 1'b0;
    step(6);
  endtask
  task results;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_wake;
    chk({SETUP_REG_O, clr[8:0], flg, LAST_OPCODE_O}, {`MSI_SETUP_RESET, 18'h0});
    POWERDOWN_WAKE_I = 1'b1;
    for (int i = 0; i < 10 && POWER_STATE_O !== MSI_PWR_RELAX; i++) step(1);
    step(6);
    POWERDOWN_WAKE_I = 1'b0;
    step(4);
    chk(POWER_STATE_O, MSI_PWR_RELAX);
  endtask
  task t_regs;
    wr(MSI_SEL_SETUP, 16'h0383);
    wr(MSI_SEL_SCRATCH_A, 16'h00a5);
    wr(MSI_SEL_DRIVE_A, 16'h0040);
    wr(MSI_SEL_DRIVE_B, 16'h0040);
    wr(MSI_SEL_SCRATCH_C, 16'h5678);
    wr(MSI_SEL_SCRATCH_D, 16'h1234);
    chk({SETUP_REG_O, clr[63:34]}, {16'h0383, 16'h00a5, 14'h2040});
    chk(clr[31:0], 32'h5678_1234);
    sio_reset();
    chk(SETUP_REG_O, `MSI_SETUP_RESET);
    chk(clr, 64'h0);
    chk(POWER_STATE_O, MSI_PWR_POWERDOWN);
  endtask
  task t_soft;
    ctrl.send(`MSI_OP_ASSERT_RST, 1'b1, 6'h00);
    ctrl.idle(2);
    chk({SOFT_RESET_O, LAST_OPCODE_O}, {1'b1, `MSI_OP_ASSERT_RST});
    wr(MSI_SEL_SCRATCH_A, 16'hbeef);
    ctrl.idle(14);
    ctrl.send(`MSI_OP_RELEASE_RST, 1'b1, 6'h00);
    ctrl.idle(4);
    chk(flg, 5'b00010);
    chk(clr, 64'h0);
    READ_DOMAIN_I = 1'b1;
    ctrl.send(`MSI_OP_FAST_CLK, 1'b1, 6'h00);
    ctrl.idle(4);
    READ_DOMAIN_I = 1'b0;
    step(8);
    chk({flg, CLEARED_REGS_O.autoskip_flag}, 6'b011101);
    chk(CLEARED_REGS_O.skip_field, 1'b1);
  endtask
  task t_err;
    ctrl.send(`MSI_OP_FAST_CLK, 1'b1, 6'h00);
    ctrl.idle(4);
    chk(SEQ_ERROR_O, 1'b1);
    sio_reset();
    chk(SEQ_ERROR_O, 1'b0);
    ctrl.send(`MSI_OP_ASSERT_RST, 1'b0, 6'h05);
    ctrl.idle(16);
    chk({SOFT_RESET_O, LAST_OPCODE_O}, {1'b0, `MSI_OP_ASSERT_RST});
    ctrl.send(`MSI_OP_ASSERT_RST, 1'b0, 6'h3f);
    ctrl.idle(8);
    chk(SOFT_RESET_O, 1'b1);
    ctrl.send(`MSI_OP_RELEASE_RST, 1'b0, 6'h3f);
    ctrl.idle(4);
    chk({SOFT_RESET_O, SEQ_ERROR_O}, 2'b01);
  endtask
  initial begin
    RESET_N_I = 1'b0;
    SIO_RESET_I = 1'b0;
    POWERDOWN_WAKE_I = 1'b0;
    READ_DOMAIN_I = 1'b0;
    REG_WR_I = '0;
    step(5);
    RESET_N_I = 1'b1;
    step(12);
    t_wake();
    t_regs();
    t_soft();
    t_err();
    results();
  end
endmodule
bind msi_top msi_checker u_chk (
  .CLK_SYS_I(CLK_SYS_I),
  .RESET_N_I(RESET_N_I),
  .SIO_RESET_I(SIO_RESET_I),
  .POWERDOWN_WAKE_I(POWERDOWN_WAKE_I),
  .SETUP_REG_O(SETUP_REG_O),
  .CLEARED_REGS_O(CLEARED_REGS_O),
  .POWER_STATE_O(POWER_STATE_O),
  .SOFT_RESET_O(SOFT_RESET_O),
  .FAST_CLOCK_O(FAST_CLOCK_O),
  .READ_DOMAIN_O(READ_DOMAIN_O),
  .CORE_DATA_UNDEFINED_O(CORE_DATA_UNDEFINED_O),
  .SEQ_ERROR_O(SEQ_ERROR_O),
  .LAST_OPCODE_O(LAST_OPCODE_O)
);
